//--- fault_response_defines.svh
// Register offsets, field positions, reset values and timing of the fault manager
`ifndef FAULT_RESPONSE_DEFINES_SVH
`define FAULT_RESPONSE_DEFINES_SVH
// ===========================================
// Register offsets
`define REG_CONFIG 8'h00
`define REG_CONTROL 8'h04
`define REG_DRIVER_LOG 8'h08
`define REG_CTRL_LOG 8'h0C
`define REG_STATE 8'h10
// ===========================================
// Config and control fields and reset values
`define CFG_OC_LSB 0
`define CFG_LOCK_LSB 4
`define CFG_ALARM_BIT 8
`define RST_OC_SEL 2'h0
`define RST_LOCK_SEL 4'h0
`define RST_ALARM_SEL 1'h0
`define CTL_CLEAR_BIT 0
// ===========================================
// Synchroniser bit positions of the fault inputs
`define SYN_OC 0
`define SYN_SPD 1
`define SYN_NOM 2
`define SYN_BEMF 3
`define SYN_CP 4
`define SYN_VM 5
`define SYN_AVDD 6
// ===========================================
// Timing
`define CLK_KHZ 250000
`define SHORT_RETRY_MS 100
`define LOCK_RETRY_MS 500
`endif

//--- fault_response_pkg.sv
// Types of the fault response manager
package fault_response_pkg;
	// Power stage drive mode
	typedef enum logic [1:0] {
		STG_ACTIVE = 2'h0,
		STG_HIZ = 2'h1,
		STG_HS_BRAKE = 2'h2,
		STG_LS_BRAKE = 2'h3
	} stage_e;
	// Overall fault state, one-hot
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_RECOVER = 4'h2,
		ST_LATCH = 4'h4,
		ST_UNDERVOLT = 4'h8
	} state_e;
	// Complete state of the manager
	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		logic [1:0] oc_sel;
		logic [3:0] lk_sel;
		logic alarm_sel;
		logic oc_lat;
		logic lk_lat;
		logic [31:0] oc_cnt;
		logic [31:0] lk_cnt;
		logic [1:0] drv_log;
		logic [3:0] ctrl_log;
		state_e state;
		stage_e stage;
		logic act;
		logic rep;
		logic pin_n;
		logic alarm;
		logic logic_en;
		logic [31:0] rdata;
	} mgr_s;
endpackage

//--- fault_response_manager.sv
// Fault response manager: actions, retry timing, pins and fault logs
`timescale 1ns/1ns
`default_nettype none
`include "fault_response_defines.svh"

module fault_response_manager #(
	parameter logic [31:0] SHORT_RETRY_CYC =
		32'(`SHORT_RETRY_MS * `CLK_KHZ),
	parameter logic [31:0] LOCK_RETRY_CYC =
		32'(`LOCK_RETRY_MS * `CLK_KHZ)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Fault detector inputs
	input wire logic phase_overcurrent,
	input wire logic speed_abnormal,
	input wire logic no_motor,
	input wire logic bemf_abnormal,
	input wire logic cp_undervolt,
	input wire logic vm_undervolt,
	input wire logic avdd_undervolt,
	// Power stage and reporting
	output fault_response_pkg::stage_e stage_mode,
	output logic logic_enable,
	output logic fault_pin_n,
	output logic alarm
);
	import fault_response_pkg::*;

	// Lock retry ranks as the slower one when it is not shorter
	localparam logic LOCK_IS_SLOW = (LOCK_RETRY_CYC >= SHORT_RETRY_CYC);

	mgr_s s;
	mgr_s n;
	logic fault_clear_bit;
	logic rotor_stall_fault;
	logic oc_latch, oc_retry, oc_rep, oc_ign;
	logic lk_latch, lk_retry, lk_rep, lk_ign;
	logic oc_pend, lk_pend, uv, cp;
	stage_e lk_stage;

	// ===========================================
	// Decode of action codes and synchronised faults
	always_comb begin
		fault_clear_bit = wr && (addr == `REG_CONTROL) && wdata[`CTL_CLEAR_BIT];
		rotor_stall_fault = s.s2[`SYN_SPD] | s.s2[`SYN_NOM] | s.s2[`SYN_BEMF];
		oc_latch = (s.oc_sel == 2'h0);
		oc_retry = (s.oc_sel == 2'h1);
		oc_rep = (s.oc_sel == 2'h2);
		oc_ign = (s.oc_sel == 2'h3);
		lk_latch = ~s.lk_sel[3] & ~s.lk_sel[2];
		lk_retry = ~s.lk_sel[3] & s.lk_sel[2];
		lk_rep = (s.lk_sel == 4'h8);
		lk_ign = s.lk_sel[3] & (s.lk_sel != 4'h8);
		if (!s.lk_sel[1]) begin
			lk_stage = STG_HIZ;
		end else if (s.lk_sel[0]) begin
			lk_stage = STG_LS_BRAKE;
		end else begin
			lk_stage = STG_HS_BRAKE;
		end
		uv = s.s2[`SYN_VM] | s.s2[`SYN_AVDD];
		cp = s.s2[`SYN_CP];
		oc_pend = (s.s2[`SYN_OC] & oc_retry) | (s.oc_cnt != 32'h0);
		lk_pend = (rotor_stall_fault & lk_retry) | (s.lk_cnt != 32'h0);
	end

	// ===========================================
	// Next state of the whole manager
	always_comb begin
		n = s;
		n.s1 = {avdd_undervolt, vm_undervolt, cp_undervolt, bemf_abnormal,
			no_motor, speed_abnormal, phase_overcurrent};
		n.s2 = s.s1;
		// Configuration writes
		if (wr && (addr == `REG_CONFIG)) begin
			n.oc_sel = wdata[`CFG_OC_LSB +: 2];
			n.lk_sel = wdata[`CFG_LOCK_LSB +: 4];
			n.alarm_sel = wdata[`CFG_ALARM_BIT];
		end
		// Latches: a fault in the clear cycle wins over the clear
		n.oc_lat = (s.s2[`SYN_OC] & oc_latch) |
			(s.oc_lat & ~fault_clear_bit);
		n.lk_lat = (rotor_stall_fault & lk_latch) |
			(s.lk_lat & ~fault_clear_bit);
		// Retry timers reload while the fault stands, then count out
		if (s.s2[`SYN_OC] & oc_retry) begin
			n.oc_cnt = SHORT_RETRY_CYC;
		end else if (s.oc_cnt != 32'h0) begin
			n.oc_cnt = s.oc_cnt - 32'h1;
		end
		if (rotor_stall_fault & lk_retry) begin
			n.lk_cnt = LOCK_RETRY_CYC;
		end else if (s.lk_cnt != 32'h0) begin
			n.lk_cnt = s.lk_cnt - 32'h1;
		end
		// Logs are sticky, cleared by the clear bit, set wins
		if (fault_clear_bit) begin
			n.drv_log = 2'h0;
			n.ctrl_log = 4'h0;
		end
		n.drv_log[0] = n.drv_log[0] | (s.s2[`SYN_OC] & ~oc_ign);
		n.drv_log[1] = n.drv_log[1] | cp;
		n.ctrl_log[0] = n.ctrl_log[0] | (rotor_stall_fault & ~lk_ign);
		n.ctrl_log[1] = n.ctrl_log[1] | (s.s2[`SYN_SPD] & ~lk_ign);
		n.ctrl_log[2] = n.ctrl_log[2] | (s.s2[`SYN_NOM] & ~lk_ign);
		n.ctrl_log[3] = n.ctrl_log[3] | (s.s2[`SYN_BEMF] & ~lk_ign);
		// Stage response: later assignments carry higher rank
		n.stage = STG_ACTIVE;
		if (cp) begin
			n.stage = STG_HIZ;
		end
		if (LOCK_IS_SLOW) begin
			if (oc_pend) begin
				n.stage = STG_HIZ;
			end
			if (lk_pend) begin
				n.stage = lk_stage;
			end
		end else begin
			if (lk_pend) begin
				n.stage = lk_stage;
			end
			if (oc_pend) begin
				n.stage = STG_HIZ;
			end
		end
		if (s.oc_lat) begin
			n.stage = STG_HIZ;
		end
		if (s.lk_lat) begin
			n.stage = lk_stage;
		end
		if (uv) begin
			n.stage = STG_HIZ;
		end
		// Overall state
		case (1'b1)
			uv: n.state = ST_UNDERVOLT;
			s.oc_lat | s.lk_lat: n.state = ST_LATCH;
			oc_pend | lk_pend | cp: n.state = ST_RECOVER;
			default: n.state = ST_ACTIVE;
		endcase
		n.logic_en = ~uv;
		// Reporting on the pins
		n.act = s.oc_lat | s.lk_lat | oc_pend | lk_pend | cp;
		n.rep = (s.s2[`SYN_OC] & oc_rep) | (rotor_stall_fault & lk_rep);
		n.pin_n = ~(n.act | (n.rep & ~n.alarm_sel));
		n.alarm = n.alarm_sel & (n.act | n.rep);
		// Register reads, data in the next cycle only
		n.rdata = 32'h0;
		if (rd) begin
			case (addr)
				`REG_CONFIG: n.rdata = {23'h0, s.alarm_sel, s.lk_sel,
					2'h0, s.oc_sel};
				`REG_CONTROL: n.rdata = 32'h0;
				`REG_DRIVER_LOG: n.rdata = {30'h0, s.drv_log};
				`REG_CTRL_LOG: n.rdata = {28'h0, s.ctrl_log};
				`REG_STATE: n.rdata = {25'h0, s.logic_en, s.stage, s.state};
				default: n.rdata = 32'h0;
			endcase
		end
	end

	// ===========================================
	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.oc_sel <= `RST_OC_SEL;
			s.lk_sel <= `RST_LOCK_SEL;
			s.alarm_sel <= `RST_ALARM_SEL;
			s.state <= ST_ACTIVE;
			s.stage <= STG_HIZ;
			s.pin_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign rdata = s.rdata;
	assign stage_mode = s.stage;
	assign logic_enable = s.logic_en;
	assign fault_pin_n = s.pin_n;
	assign alarm = s.alarm;

	// ===========================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_latch_pin;
		(s.state == ST_LATCH) |-> !fault_pin_n;
	endproperty
	a_latch_pin: assert property (p_latch_pin)
		else $error("fault pin released while latched");

	property p_alarm_act;
		$rose(s.act) && s.alarm_sel && $stable(s.alarm_sel) |-> alarm;
	endproperty
	a_alarm_act: assert property (p_alarm_act)
		else $error("alarm missing for actionable fault");

	property p_report_only;
		s.alarm_sel && s.rep && !s.act |-> fault_pin_n && alarm;
	endproperty
	a_report_only: assert property (p_report_only)
		else $error("report-only fault handled wrongly");

	property p_latch_hold;
		(s.oc_lat || s.lk_lat) && !fault_clear_bit && !uv |=>
			(s.state == ST_LATCH) && (stage_mode != STG_ACTIVE);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched fault released without clear");

	property p_clear;
		(s.state == ST_LATCH) && fault_clear_bit && !s.s2[`SYN_OC] &&
			!rotor_stall_fault |=> ##1 (s.state != ST_LATCH);
	endproperty
	a_clear: assert property (p_clear)
		else $error("latched fault not cleared");

	property p_active_timers;
		(s.state == ST_ACTIVE) |-> (s.oc_cnt == 32'h0) && (s.lk_cnt == 32'h0);
	endproperty
	a_active_timers: assert property (p_active_timers)
		else $error("stage active during retry time");

	property p_retry_end;
		(s.state == ST_RECOVER) && !uv && !cp && !s.oc_lat && !s.lk_lat &&
			!s.s2[`SYN_OC] && !rotor_stall_fault &&
			(s.oc_cnt == 32'h0) && (s.lk_cnt == 32'h0) |=>
			(s.state == ST_ACTIVE) && (stage_mode == STG_ACTIVE);
	endproperty
	a_retry_end: assert property (p_retry_end)
		else $error("stage not restored after retry");

	property p_off_reported;
		(stage_mode != STG_ACTIVE) && (s.state != ST_UNDERVOLT) &&
			$stable(s.state) && !$past(rst) |-> !fault_pin_n;
	endproperty
	a_off_reported: assert property (p_off_reported)
		else $error("forced-off stage not reported");

	property p_oc_ignore;
		s.s2[`SYN_OC] && oc_ign && !s.drv_log[0] |=> !s.drv_log[0];
	endproperty
	a_oc_ignore: assert property (p_oc_ignore)
		else $error("ignored overcurrent logged");

	property p_uv;
		uv |=> (s.state == ST_UNDERVOLT) && (stage_mode == STG_HIZ) &&
			!logic_enable;
	endproperty
	a_uv: assert property (p_uv)
		else $error("undervoltage response wrong");

	property p_clear_reads_zero;
		rd && (addr == `REG_CONTROL) |=> (rdata == 32'h0);
	endproperty
	a_clear_reads_zero: assert property (p_clear_reads_zero)
		else $error("clear bit reads non-zero");

	property p_retry_pin;
		oc_pend || lk_pend |=> !fault_pin_n;
	endproperty
	a_retry_pin: assert property (p_retry_pin)
		else $error("fault pin released during retry");

	property p_alarm_retry;
		(oc_pend || lk_pend) && s.alarm_sel && !wr |=> alarm;
	endproperty
	a_alarm_retry: assert property (p_alarm_retry)
		else $error("alarm missing during retry");

	property p_rank_latch;
		s.oc_lat && !s.lk_lat && !uv |=> (stage_mode == STG_HIZ);
	endproperty
	a_rank_latch: assert property (p_rank_latch)
		else $error("latched overcurrent outranked");

	property p_longer_retry;
		(s.oc_cnt != 32'h0) || (s.lk_cnt != 32'h0) |=>
			(stage_mode != STG_ACTIVE) && (s.state != ST_ACTIVE);
	endproperty
	a_longer_retry: assert property (p_longer_retry)
		else $error("stage active while a retry timer runs");

	property p_retry_reload;
		s.s2[`SYN_OC] && oc_retry |=> (s.oc_cnt == SHORT_RETRY_CYC);
	endproperty
	a_retry_reload: assert property (p_retry_reload)
		else $error("retry timer not reloaded by fault");

	property p_lock_brake;
		s.lk_lat && !uv && (s.lk_sel == 4'h2) |=>
			(stage_mode == STG_HS_BRAKE);
	endproperty
	a_lock_brake: assert property (p_lock_brake)
		else $error("latched stall brake wrong");

	property p_lock_retry_brake;
		lk_pend && !oc_pend && !s.oc_lat && !s.lk_lat && !uv &&
			(s.lk_sel == 4'h7) |=> (stage_mode == STG_LS_BRAKE);
	endproperty
	a_lock_retry_brake: assert property (p_lock_retry_brake)
		else $error("retrying stall brake wrong");

	property p_lock_ignore;
		rotor_stall_fault && lk_ign && !s.ctrl_log[0] |=> !s.ctrl_log[0];
	endproperty
	a_lock_ignore: assert property (p_lock_ignore)
		else $error("ignored stall logged");

	property p_stall_log;
		rotor_stall_fault && !lk_ign |=> s.ctrl_log[0];
	endproperty
	a_stall_log: assert property (p_stall_log)
		else $error("stall not logged");

	property p_clear_pulse;
		fault_clear_bit && !s.s2[`SYN_OC] |=> !s.drv_log[0] && !s.oc_lat;
	endproperty
	a_clear_pulse: assert property (p_clear_pulse)
		else $error("clear pulse left overcurrent state");
endmodule
`default_nettype wire

//--- host_model.sv
// Host model: register bus master that reads logs and clears faults
`timescale 1ns/1ns
`default_nettype none
`include "fault_response_defines.svh"
module host_model (
	// Clock
	input wire logic mclk,
	// Register bus toward the device
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd
);
	// ====
	// Bus idle at time zero
	initial begin
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end
	// One-cycle write; released lines show the inverse afterwards
	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	// One-cycle read; the bench monitor takes the data
	task automatic read_reg(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		addr <= ~a;
	endtask
	// Clear latched faults, then allow the device time to act
	task automatic clear_faults();
		write_reg(`REG_CONTROL, 32'h1);
		repeat (4) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Testbench of the fault response manager
`timescale 1ns/1ns
`default_nettype none
`include "fault_response_defines.svh"
module testbench;
	import fault_response_pkg::*;
	// ====
	// Signals
	localparam logic [31:0] SHORT_CYC = 32'h14;
	localparam logic [31:0] LOCK_CYC = 32'h32;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic oc = 1'b0;
	logic cp = 1'b0;
	logic [2:0] lk = 3'h0;
	logic [1:0] uv = 2'h0;
	wire logic [7:0] addr;
	wire logic [31:0] wdata;
	wire logic wr, rd;
	logic [31:0] rdata;
	stage_e stage_mode;
	logic logic_enable, fault_pin_n, alarm, rd_q = 1'b0;
	logic [31:0] exp_q[$];
	integer seed, num_errors = 0, total_checks = 0, cycles = 0, src;
	logic [2:0] resp;
	logic [3:0] lg;
	always #2 mclk = ~mclk;
	host_model host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd));
	fault_response_manager #(.SHORT_RETRY_CYC(SHORT_CYC),
		.LOCK_RETRY_CYC(LOCK_CYC)) dut (.mclk(mclk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.phase_overcurrent(oc), .speed_abnormal(lk[0]), .no_motor(lk[1]),
		.bemf_abnormal(lk[2]), .cp_undervolt(cp), .vm_undervolt(uv[0]),
		.avdd_undervolt(uv[1]), .stage_mode(stage_mode),
		.logic_enable(logic_enable), .fault_pin_n(fault_pin_n),
		.alarm(alarm));
	// ====
	// Checking and reporting
	task automatic fail(input logic [31:0] got, exp);
		num_errors++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
	endtask
	task automatic check_word(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp)
			fail(got, exp);
	endtask
	// Compare stage, enable, pin and alarm mid-cycle
	task automatic check_out(input logic [1:0] s, input logic e, p, a);
		@(negedge mclk);
		total_checks++;
		if ({stage_mode, logic_enable, fault_pin_n, alarm} !== {s, e, p, a})
			fail(32'({stage_mode, logic_enable, fault_pin_n, alarm}),
				32'({s, e, p, a}));
		@(posedge mclk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		host.read_reg(a);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic final_report();
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Expected {stage, pin} of a lock action code
	function automatic logic [2:0] lock_resp(input logic [3:0] c);
		if (c == 4'h8)
			return {STG_ACTIVE, 1'b0};
		if (c[3])
			return {STG_ACTIVE, 1'b1};
		if (c[1:0] == 2'h2)
			return {STG_HS_BRAKE, 1'b0};
		if (c[1:0] == 2'h3)
			return {STG_LS_BRAKE, 1'b0};
		return {STG_HIZ, 1'b0};
	endfunction
	// Read data monitor: oldest note against the word after each read
	always @(posedge mclk) begin
		if (rd_q === 1'b1)
			check_word(rdata, exp_q.pop_front());
		rd_q <= rd;
	end
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			final_report();
		end
	end
	// Main sequence
	initial begin
		seed = 32'hDB4A194E;
		step(4);
		rst <= 1'b0;
		step(1);
		rd_chk(`REG_CONFIG, 32'h0);
		rd_chk(`REG_CONTROL, 32'h0);
		host.write_reg(8'h14, $random(seed));
		rd_chk(8'h14, 32'h0);
		check_out(STG_ACTIVE, 1'h1, 1'h1, 1'h0);
		// Latched overcurrent holds until cleared
		oc <= 1'b1;
		step(4);
		check_out(STG_HIZ, 1'h1, 1'h0, 1'h0);
		oc <= 1'b0;
		step(SHORT_CYC + 10);
		check_out(STG_HIZ, 1'h1, 1'h0, 1'h0);
		rd_chk(`REG_STATE, {25'h0, 1'b1, STG_HIZ, ST_LATCH});
		rd_chk(`REG_DRIVER_LOG, 32'h1);
		host.clear_faults();
		check_out(STG_ACTIVE, 1'h1, 1'h1, 1'h0);
		rd_chk(`REG_DRIVER_LOG, 32'h0);
		// Report-only overcurrent with both alarm selections
		for (int a = 0; a < 2; a++) begin
			host.write_reg(`REG_CONFIG, 32'h2 | (a << 8));
			oc <= 1'b1;
			step(4);
			check_out(STG_ACTIVE, 1'h1, a[0], a[0]);
			oc <= 1'b0;
			host.clear_faults();
		end
		// Retrying overcurrent with the alarm on
		host.write_reg(`REG_CONFIG, 32'h101);
		oc <= 1'b1;
		step(4);
		check_out(STG_HIZ, 1'h1, 1'h0, 1'h1);
		oc <= 1'b0;
		step(SHORT_CYC / 2);
		check_out(STG_HIZ, 1'h1, 1'h0, 1'h1);
		step(SHORT_CYC);
		check_out(STG_ACTIVE, 1'h1, 1'h1, 1'h0);
		host.clear_faults();
		// Ignored overcurrent does nothing
		host.write_reg(`REG_CONFIG, 32'h3);
		oc <= 1'b1;
		step(4);
		check_out(STG_ACTIVE, 1'h1, 1'h1, 1'h0);
		oc <= 1'b0;
		rd_chk(`REG_DRIVER_LOG, 32'h0);
		// Every lock action code from a random detector
		for (int c = 0; c < 16; c++) begin
			resp = lock_resp(4'(c));
			src = {$random(seed)} % 3;
			host.write_reg(`REG_CONFIG, 32'(c) << 4);
			lk[src] <= 1'b1;
			step(4);
			check_out(resp[2:1], 1'h1, resp[0], 1'h0);
			lk <= 3'h0;
			lg = 4'(4'h1 | (4'h2 << src));
			rd_chk(`REG_CTRL_LOG, resp[0] ? 32'h0 : 32'(lg));
			host.clear_faults();
			step(LOCK_CYC + 8);
			check_out(STG_ACTIVE, 1'h1, 1'h1, 1'h0);
		end
		// Two retry faults wait for the longer time
		host.write_reg(`REG_CONFIG, 32'h41);
		oc <= 1'b1;
		lk <= 3'h1;
		step(4);
		oc <= 1'b0;
		lk <= 3'h0;
		step(LOCK_CYC - 10);
		check_out(STG_HIZ, 1'h1, 1'h0, 1'h0);
		step(25);
		check_out(STG_ACTIVE, 1'h1, 1'h1, 1'h0);
		// A latched fault outranks a braking retry fault
		host.write_reg(`REG_CONFIG, 32'h60);
		oc <= 1'b1;
		lk <= 3'h4;
		step(4);
		check_out(STG_HIZ, 1'h1, 1'h0, 1'h0);
		oc <= 1'b0;
		lk <= 3'h0;
		step(LOCK_CYC + 10);
		check_out(STG_HIZ, 1'h1, 1'h0, 1'h0);
		host.clear_faults();
		// Charge pump undervoltage: off and reported until it leaves
		cp <= 1'b1;
		step(4);
		check_out(STG_HIZ, 1'h1, 1'h0, 1'h0);
		cp <= 1'b0;
		rd_chk(`REG_DRIVER_LOG, 32'h2);
		host.clear_faults();
		check_out(STG_ACTIVE, 1'h1, 1'h1, 1'h0);
		// Supply undervoltage from a random source
		uv[{$random(seed)} % 2] <= 1'b1;
		step(4);
		check_out(STG_HIZ, 1'h0, 1'h1, 1'h0);
		uv <= 2'h0;
		step(4);
		check_out(STG_ACTIVE, 1'h1, 1'h1, 1'h0);
		final_report();
	end
endmodule
`default_nettype wire
